// ===== hdl/alert_threshold_registers.sv
// Alert threshold register bank with its limit comparators and alert bits.
`default_nettype none

module alert_threshold_registers
  import alert_threshold_pkg::*;
#(
  // Arbitrary neutral value; replace with the real maker code.
  parameter logic [15:0] MAKER_CODE = 16'h5858
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire reg_req_t reg_req_i,
  output reg_rsp_t reg_rsp_o,
  input wire logic result_valid_i,
  input wire results_t results_i,
  input wire logic alert_latch_enable_i,
  input wire logic diag_read_i,
  output flags_t alert_flags_o
);

  bank_state_t state;
  bank_state_t next_state;
  flags_t trip;

  always_comb begin
    next_state = state;
    next_state.rsp.valid = reg_req_i.rd;
    next_state.rsp.rdata = 16'h0000;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        OFS_CURRENT_OVER: begin
          next_state.rsp.rdata = state.limits.current_over;
        end
        OFS_CURRENT_UNDER: begin
          next_state.rsp.rdata = state.limits.current_under;
        end
        OFS_BUS_OVER: begin
          // The top bit stays at zero.
          next_state.rsp.rdata[BUS_FIELD_MSB:0] = state.limits.bus_over;
        end
        OFS_BUS_UNDER: begin
          next_state.rsp.rdata[BUS_FIELD_MSB:0] = state.limits.bus_under;
        end
        OFS_OVERTEMP: begin
          // Low nibble stays at zero.
          next_state.rsp.rdata[TEMP_FIELD_MSB:TEMP_FIELD_LSB] =
            state.limits.overtemp;
        end
        OFS_OVERPOWER: begin
          next_state.rsp.rdata = state.limits.overpower;
        end
        OFS_MAKER: begin
          next_state.rsp.rdata = MAKER_CODE;
        end
        default: begin
          next_state.rsp.rdata = 16'h0000;
        end
      endcase
    end
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        OFS_CURRENT_OVER: begin
          next_state.limits.current_over = reg_req_i.wdata;
        end
        OFS_CURRENT_UNDER: begin
          next_state.limits.current_under = reg_req_i.wdata;
        end
        OFS_BUS_OVER: begin
          // Reserved bit is dropped on write.
          next_state.limits.bus_over = reg_req_i.wdata[BUS_FIELD_MSB:0];
        end
        OFS_BUS_UNDER: begin
          // Reserved bit is dropped on write.
          next_state.limits.bus_under = reg_req_i.wdata[BUS_FIELD_MSB:0];
        end
        OFS_OVERTEMP: begin
          // Reserved nibble is dropped on write.
          next_state.limits.overtemp =
            reg_req_i.wdata[TEMP_FIELD_MSB:TEMP_FIELD_LSB];
        end
        OFS_OVERPOWER: begin
          next_state.limits.overpower = reg_req_i.wdata;
        end
        default: begin
          // The maker code and unmapped addresses ignore writes.
          next_state.limits = state.limits;
        end
      endcase
    end
    if (!rstn_i) begin
      next_state = BANK_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    state <= next_state;
  end

  assign reg_rsp_o = state.rsp;

  // Comparisons use the limits as stored, so a write takes effect on the
  // result sampled one cycle after the write.
  limit_compare #(
    .WIDTH(16),
    .SIGNED(1'b1),
    .OVER(1'b1)
  ) u_current_over (
    .value_i(results_i.current),
    .limit_i(state.limits.current_over),
    .trip_o(trip.overcurrent_flag)
  );

  limit_compare #(
    .WIDTH(16),
    .SIGNED(1'b1),
    .OVER(1'b0)
  ) u_current_under (
    .value_i(results_i.current),
    .limit_i(state.limits.current_under),
    .trip_o(trip.undercurrent_flag)
  );

  limit_compare #(
    .WIDTH(16),
    .SIGNED(1'b0),
    .OVER(1'b1)
  ) u_bus_over (
    .value_i(results_i.bus),
    .limit_i({1'b0, state.limits.bus_over}),
    .trip_o(trip.bus_over_flag)
  );

  limit_compare #(
    .WIDTH(16),
    .SIGNED(1'b0),
    .OVER(1'b0)
  ) u_bus_under (
    .value_i(results_i.bus),
    .limit_i({1'b0, state.limits.bus_under}),
    .trip_o(trip.bus_under_flag)
  );

  limit_compare #(
    .WIDTH(12),
    .SIGNED(1'b1),
    .OVER(1'b1)
  ) u_overtemp (
    .value_i(
      results_i.die_temperature_result[TEMP_FIELD_MSB:TEMP_FIELD_LSB]),
    .limit_i(state.limits.overtemp),
    .trip_o(trip.overtemperature_flag)
  );

  // Each limit step is 256 power steps, so only the upper word counts.
  limit_compare #(
    .WIDTH(16),
    .SIGNED(1'b0),
    .OVER(1'b1)
  ) u_overpower (
    .value_i(results_i.power[POWER_RESULT_MSB:POWER_RESULT_LSB]),
    .limit_i(state.limits.overpower),
    .trip_o(trip.overpower_flag)
  );

  for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
    alert_flag_bit u_flag (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .sample_i(result_valid_i),
      .trip_i(trip[i]),
      .latch_i(alert_latch_enable_i),
      .clear_i(diag_read_i),
      .flag_o(alert_flags_o[i])
    );
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_read(logic [7:0] ofs);
    reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == ofs;
  endsequence

  sequence s_write(logic [7:0] ofs);
    reg_req_i.wr && reg_req_i.addr == ofs;
  endsequence

  property p_reset_values;
    $rose(rstn_i) |-> state.limits == BANK_RESET.limits;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("Threshold limits left reset with wrong values.");

  property p_current_over_write;
    s_write(OFS_CURRENT_OVER) |=>
      state.limits.current_over == $past(reg_req_i.wdata);
  endproperty
  a_current_over_write: assert property (p_current_over_write)
    else $error("Current over limit write not stored.");

  property p_cur_under_readback;
    s_write(OFS_CURRENT_UNDER) ##1 s_read(OFS_CURRENT_UNDER) |=>
      reg_rsp_o.valid && reg_rsp_o.rdata == $past(reg_req_i.wdata, 2);
  endproperty
  a_cur_under_readback: assert property (p_cur_under_readback)
    else $error("Current under limit did not read back its write.");

  property p_bus_over_read;
    s_read(OFS_BUS_OVER) |=> reg_rsp_o.valid && !reg_rsp_o.rdata[15] &&
      reg_rsp_o.rdata[14:0] == $past(state.limits.bus_over);
  endproperty
  a_bus_over_read: assert property (p_bus_over_read)
    else $error("Bus over limit read wrong or reserved bit set.");

  property p_bus_under_write;
    s_write(OFS_BUS_UNDER) ##1 s_read(OFS_BUS_UNDER) |=>
      reg_rsp_o.rdata == {1'b0, $past(reg_req_i.wdata[14:0], 2)};
  endproperty
  a_bus_under_write: assert property (p_bus_under_write)
    else $error("Bus under limit write or readback wrong.");

  property p_overtemp_read;
    s_read(OFS_OVERTEMP) |=> reg_rsp_o.rdata[3:0] == 4'h0 &&
      reg_rsp_o.rdata[15:4] == $past(state.limits.overtemp);
  endproperty
  a_overtemp_read: assert property (p_overtemp_read)
    else $error("Temperature limit read wrong or low nibble set.");

  property p_overtemp_write;
    s_write(OFS_OVERTEMP) |=>
      state.limits.overtemp == $past(reg_req_i.wdata[15:4]);
  endproperty
  a_overtemp_write: assert property (p_overtemp_write)
    else $error("Temperature limit write not masked to its field.");

  property p_overpower_write;
    s_write(OFS_OVERPOWER) |=>
      state.limits.overpower == $past(reg_req_i.wdata);
  endproperty
  a_overpower_write: assert property (p_overpower_write)
    else $error("Power limit write not stored.");

  property p_maker_read;
    s_read(OFS_MAKER) |=> reg_rsp_o.valid && reg_rsp_o.rdata == MAKER_CODE;
  endproperty
  a_maker_read: assert property (p_maker_read)
    else $error("Maker code read returned a wrong value.");

  property p_overcurrent;
    result_valid_i && $signed(results_i.current) >
      $signed(state.limits.current_over) |=> alert_flags_o.overcurrent_flag;
  endproperty
  a_overcurrent: assert property (p_overcurrent)
    else $error("Current above its limit did not raise the alert.");

  property p_negative_limit_zero;
    result_valid_i && results_i.current == 16'h0000 &&
      state.limits.current_over[15] |=> alert_flags_o.overcurrent_flag;
  endproperty
  a_negative_limit_zero: assert property (p_negative_limit_zero)
    else $error("Zero current missed a negative over limit.");

  property p_overtemp_trip;
    result_valid_i && $signed(results_i.die_temperature_result[15:4]) >
      $signed(state.limits.overtemp) |=> alert_flags_o.overtemperature_flag;
  endproperty
  a_overtemp_trip: assert property (p_overtemp_trip)
    else $error("Temperature above its limit did not raise the alert.");

  property p_overpower_trip;
    result_valid_i && results_i.power[23:8] > state.limits.overpower
      |=> alert_flags_o.overpower_flag;
  endproperty
  a_overpower_trip: assert property (p_overpower_trip)
    else $error("Power above its limit did not raise the alert.");

  property p_bus_under_trip;
    result_valid_i && results_i.bus < {1'b0, state.limits.bus_under}
      |=> alert_flags_o.bus_under_flag;
  endproperty
  a_bus_under_trip: assert property (p_bus_under_trip)
    else $error("Bus voltage below its limit did not raise the alert.");

endmodule

`default_nettype wire

// ===== shared/alert_threshold_pkg.sv
// Constants, register map and carrier types of the alert threshold bank.
`default_nettype none

package alert_threshold_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int FLAG_COUNT = 6;

  localparam logic [7:0] OFS_CURRENT_OVER = 8'h0c;
  localparam logic [7:0] OFS_CURRENT_UNDER = 8'h0d;
  localparam logic [7:0] OFS_BUS_OVER = 8'h0e;
  localparam logic [7:0] OFS_BUS_UNDER = 8'h0f;
  localparam logic [7:0] OFS_OVERTEMP = 8'h10;
  localparam logic [7:0] OFS_OVERPOWER = 8'h11;
  localparam logic [7:0] OFS_MAKER = 8'h3e;

  localparam int BUS_FIELD_MSB = 14;
  localparam int TEMP_FIELD_MSB = 15;
  localparam int TEMP_FIELD_LSB = 4;
  localparam int POWER_RESULT_MSB = 23;
  localparam int POWER_RESULT_LSB = 8;

  localparam logic [15:0] RST_CURRENT_OVER = 16'h7fff;
  localparam logic [15:0] RST_CURRENT_UNDER = 16'h8000;
  localparam logic [14:0] RST_BUS_OVER = 15'h7fff;
  localparam logic [14:0] RST_BUS_UNDER = 15'h0000;
  localparam logic [11:0] RST_OVERTEMP = 12'h7ff;
  localparam logic [15:0] RST_OVERPOWER = 16'hffff;

  typedef struct packed {
    logic [15:0] current_over;
    logic [15:0] current_under;
    logic [14:0] bus_over;
    logic [14:0] bus_under;
    logic [11:0] overtemp;
    logic [15:0] overpower;
  } limits_t;

  typedef struct packed {
    logic overcurrent_flag;
    logic undercurrent_flag;
    logic bus_over_flag;
    logic bus_under_flag;
    logic overtemperature_flag;
    logic overpower_flag;
  } flags_t;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] bus;
    logic [15:0] die_temperature_result;
    logic [23:0] power;
  } results_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    limits_t limits;
    reg_rsp_t rsp;
  } bank_state_t;

  typedef struct packed {
    logic flag;
  } flag_state_t;

  localparam bank_state_t BANK_RESET = '{
    limits: '{
      current_over: RST_CURRENT_OVER,
      current_under: RST_CURRENT_UNDER,
      bus_over: RST_BUS_OVER,
      bus_under: RST_BUS_UNDER,
      overtemp: RST_OVERTEMP,
      overpower: RST_OVERPOWER
    },
    rsp: '{valid: 1'b0, rdata: 16'h0000}
  };

endpackage

`default_nettype wire

// ===== hdl/limit_compare.sv
// One threshold comparator, signed or unsigned, over or under.
`default_nettype none

module limit_compare #(
  parameter int WIDTH = 16,
  parameter bit SIGNED = 1'b1,
  parameter bit OVER = 1'b1
) (
  input wire logic [WIDTH-1:0] value_i,
  input wire logic [WIDTH-1:0] limit_i,
  output logic trip_o
);

  if (WIDTH < 2) begin : g_bad_width
    $error("limit_compare needs at least two bits");
  end

  always_comb begin
    if (SIGNED) begin
      // A negative over limit is below zero, so a zero result trips.
      trip_o = OVER ? ($signed(value_i) > $signed(limit_i))
                    : ($signed(value_i) < $signed(limit_i));
    end else begin
      trip_o = OVER ? (value_i > limit_i) : (value_i < limit_i);
    end
  end

endmodule

`default_nettype wire

// ===== hdl/alert_flag_bit.sv
// One diagnostic alert bit with optional latching and, while latching, clear on read.
`default_nettype none

module alert_flag_bit
  import alert_threshold_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sample_i,
  input wire logic trip_i,
  input wire logic latch_i,
  input wire logic clear_i,
  output logic flag_o
);

  flag_state_t state;
  flag_state_t next_state;

  always_comb begin
    next_state = state;
    if (latch_i) begin
      // A trip in the clearing cycle wins, so no event is lost.
      next_state.flag = (state.flag & ~clear_i) | (sample_i & trip_i);
    end else if (sample_i) begin
      next_state.flag = trip_i;
    end
    if (!rstn_i) begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    state <= next_state;
  end

  assign flag_o = state.flag;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_set;
    sample_i && trip_i;
  endsequence

  sequence s_hold;
    latch_i && flag_o && !clear_i;
  endsequence

  property p_latched_hold;
    s_hold |=> flag_o;
  endproperty
  a_latched_hold: assert property (p_latched_hold)
    else $error("Latched alert bit dropped without a read.");

  property p_read_clears;
    latch_i && clear_i && !(sample_i && trip_i) |=> !flag_o;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("Alert bit not cleared by the register read.");

  property p_set_on_trip;
    s_set |=> flag_o;
  endproperty
  a_set_on_trip: assert property (p_set_on_trip)
    else $error("Tripped comparison did not set its alert bit.");

endmodule

`default_nettype wire

// ===== testbench/alert_host_model.sv
// Behavioural host that reaches the threshold registers.
`default_nettype none

module alert_host_model
  import alert_threshold_pkg::*;
(
  input wire logic clk_i,
  output var reg_req_t reg_req_o,
  input wire reg_rsp_t reg_rsp_i
);
  timeunit 1ns;
  timeprecision 1ns;

  initial reg_req_o = '0;

  // Released lines show the inverse of the last value, so a bank that
  // samples outside its strobe sees garbage instead of a lucky copy.
  task automatic release_bus();
    reg_req_o.wr = 1'b0;
    reg_req_o.rd = 1'b0;
    reg_req_o.addr = ~reg_req_o.addr;
    reg_req_o.wdata = ~reg_req_o.wdata;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i);
    reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    release_bus();
  endtask

  // The answer stands for one cycle only, so it is taken at the first
  // falling edge after the request edge.
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d,
      output bit ok);
    @(negedge clk_i);
    reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~reg_req_o.wdata};
    d = 16'h0000;
    ok = 1'b0;
    @(negedge clk_i);
    release_bus();
    if (reg_rsp_i.valid === 1'b1) begin
      d = reg_rsp_i.rdata;
      ok = 1'b1;
    end
  endtask

  // A write chained straight into a read of the same register, so the
  // read must already see the new value.
  task automatic write_read(input logic [7:0] a, input logic [15:0] d,
      output logic [15:0] q, output bit ok);
    @(negedge clk_i);
    reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    q = 16'h0000;
    ok = 1'b0;
    @(negedge clk_i);
    reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~d};
    @(negedge clk_i);
    release_bus();
    if (reg_rsp_i.valid === 1'b1) begin
      q = reg_rsp_i.rdata;
      ok = 1'b1;
    end
  endtask
endmodule

`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the alert threshold register bank.
`default_nettype none

module tb_top
  import alert_threshold_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Arbitrary neutral maker code, not the value of any real part.
  localparam logic [15:0] MAKER = 16'h3c96;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  reg_req_t req;
  reg_rsp_t rsp;
  logic res_valid = 1'b0;
  results_t res = '0;
  logic latch_en = 1'b0;
  logic diag_rd = 1'b0;
  flags_t flags;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] ofs [7] = '{OFS_CURRENT_OVER, OFS_CURRENT_UNDER, OFS_BUS_OVER,
    OFS_BUS_UNDER, OFS_OVERTEMP, OFS_OVERPOWER, OFS_MAKER};
  logic [15:0] rst_val [7] = '{16'h7fff, 16'h8000, 16'h7fff, 16'h0000,
    16'h7ff0, 16'hffff, MAKER};
  logic [15:0] rw_mask [6] = '{16'hffff, 16'hffff, 16'h7fff, 16'h7fff,
    16'hfff0, 16'hffff};
  results_t r_in = '{16'h0000, 16'h0800, 16'h0300, 24'h010000};

  always #50 clk = ~clk;

  alert_host_model i_host (.clk_i(clk), .reg_req_o(req), .reg_rsp_i(rsp));

  alert_threshold_registers #(.MAKER_CODE(MAKER)) i_dut (
    .clk_i(clk), .rstn_i(rstn), .reg_req_i(req), .reg_rsp_o(rsp),
    .result_valid_i(res_valid), .results_i(res),
    .alert_latch_enable_i(latch_en), .diag_read_i(diag_rd),
    .alert_flags_o(flags));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    bit ok;
    i_host.read_reg(a, d, ok);
    if (!ok) begin
      miscompares++;
      tally_and_finish();
    end
    check(d, exp);
  endtask

  // One conversion result and an optional alert register read together.
  task automatic sample(input logic v, input results_t r, input logic clr,
      input logic [5:0] exp);
    @(negedge clk);
    res = r;
    res_valid = v;
    diag_rd = clr;
    @(negedge clk);
    res_valid = 1'b0;
    diag_rd = 1'b0;
    check({10'h000, flags}, {10'h000, exp});
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rd_chk(ofs[i], rst_val[i]);
    end
    for (int i = 4; i < 7; i++) begin
      rd_chk(ofs[i], rst_val[i]);
    end
    check({10'h000, flags}, 16'h0000);
  endtask

  task automatic t_access();
    for (int i = 0; i < 6; i++) begin
      i_host.write_reg(ofs[i], 16'hffff);
      rd_chk(ofs[i], rw_mask[i]);
      i_host.write_reg(ofs[i], 16'h0000);
      rd_chk(ofs[i], 16'h0000);
    end
    i_host.write_reg(OFS_MAKER, 16'h0000);
    rd_chk(OFS_MAKER, MAKER);
    i_host.write_reg(8'h20, 16'hffff);
    rd_chk(8'h20, 16'h0000);
    rd_chk(OFS_CURRENT_OVER, 16'h0000);
  endtask

  // Back-to-back write and read: the read sees the value just written.
  task automatic t_chain();
    logic [15:0] q;
    bit ok;
    i_host.write_read(OFS_CURRENT_UNDER, 16'h9abc, q, ok);
    check({15'h0000, ok}, 16'h0001);
    check(q, 16'h9abc);
    i_host.write_read(OFS_BUS_UNDER, 16'hc321, q, ok);
    check({15'h0000, ok}, 16'h0001);
    check(q, 16'h4321);
  endtask

  // Transparent mode: each bit follows the last sampled comparison, and
  // equality with a limit never trips because the compares are strict.
  task automatic t_compare();
    results_t tbl [5] = '{r_in,
      '{16'h0100, 16'h1000, 16'h0500, 24'h0200ff},
      '{16'h0101, 16'h1001, 16'h0510, 24'h020100},
      '{16'hfeff, 16'h00ff, 16'h0300, 24'h000000},
      '{16'h8000, 16'hffff, 16'hfff0, 24'hffffff}};
    logic [5:0] exp [5] = '{6'b000000, 6'b000000, 6'b101011, 6'b010100,
      6'b011001};
    i_host.write_reg(OFS_CURRENT_OVER, 16'h0100);
    i_host.write_reg(OFS_CURRENT_UNDER, 16'hff00);
    i_host.write_reg(OFS_BUS_OVER, 16'h1000);
    i_host.write_reg(OFS_BUS_UNDER, 16'h0100);
    i_host.write_reg(OFS_OVERTEMP, 16'h0500);
    i_host.write_reg(OFS_OVERPOWER, 16'h0200);
    for (int i = 0; i < 5; i++) begin
      sample(1'b1, tbl[i], 1'b0, exp[i]);
    end
    sample(1'b0, r_in, 1'b1, 6'b011001);
  endtask

  task automatic t_latch();
    results_t r_mid = '{16'hff80, 16'h0800, 16'h0300, 24'h010000};
    // Bits left over from the compare scenario would stay latched, so
    // they are brought to zero while the bank is still transparent.
    sample(1'b1, r_in, 1'b0, 6'b000000);
    latch_en = 1'b1;
    i_host.write_reg(OFS_CURRENT_OVER, 16'hffff);
    sample(1'b1, r_in, 1'b0, 6'b100000);
    sample(1'b1, r_mid, 1'b0, 6'b100000);
    sample(1'b0, r_mid, 1'b1, 6'b000000);
    sample(1'b1, r_in, 1'b1, 6'b100000);
    sample(1'b0, r_in, 1'b1, 6'b000000);
  endtask

  // A second reset in mid-run restores the limits and drops a latched bit.
  task automatic t_reset_again();
    sample(1'b1, r_in, 1'b0, 6'b100000);
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_reset();
  endtask

  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_access();
    t_chain();
    t_compare();
    t_latch();
    t_reset_again();
    tally_and_finish();
  end
endmodule

`default_nettype wire
